//--- rtl/gct_timer_set.sv
// Summary of operation
// - Each timer signals its pin at reference match
// - Per timer choice: low pulse or toggle
// - Match output can clock another timer
// - Gate pin permits counting and restarts it
// - Low gate serves timers 1-2, high 3-4
// - Source: timer, clock, clock/16, input pin
// - Four input pins, rising, falling or both
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module gct_timer_set
  import gct_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               ce,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [DATA_W-1:0]  pwdata,
  output logic      [DATA_W-1:0]  prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Gate pins, high lets a gated timer count
  input  wire logic               gate_in_low_pair,
  input  wire logic               gate_in_high_pair,
  // Timer input pins
  input  wire logic               timer_in_pin_one,
  input  wire logic               timer_in_pin_two,
  input  wire logic               timer_in_pin_three,
  input  wire logic               timer_in_pin_four,
  // Timer output pins, bit 0 is timer 1
  output logic      [NTMR-1:0]    timer_out_pins
);

  // Register file and bus state
  typedef struct packed {
    gct_mode_s [NTMR-1:0]             mode;   // Mode per timer
    logic      [NTMR-1:0][CNT_W-1:0]  refv;   // Reference per timer
    logic      [NTMR-1:0][CNT_W-1:0]  cap;    // Captured count
    logic      [NTMR-1:0][EVT_W-1:0]  evt;    // Sticky events
    logic      [NTMR-1:0]             gsel;   // Gate steers timer
    logic      [DIV_W-1:0]            div;    // Shared prescaler
    logic      [DATA_W-1:0]           prdata; // Read data
    logic                             slverr; // Unmapped address
    logic                             rdy;    // Read data latched
  } gct_set_s;

  gct_set_s st_r;   // State
  gct_set_s st_nxt; // Next state

  // Register map, one aligned word per register:
  //   Timer n block at n-1 times 0x20
  //   +0x00 mode: enable, return at match, gate restart,
  //         toggle, edge choice, count source
  //   +0x04 reference, sixteen bits
  //   +0x08 count, any write clears it to zero
  //   +0x0c capture, read only, count at chosen pin edge
  //   +0x10 events: match and capture, write one to clear
  //   0x080 gate selection, one bit per timer
  //   0x084 status: output levels low, gate levels high
  // Unused bits read zero and ignore writes
  // Unmapped addresses answer with an error and zero data

  // One interface per timer carries mode, reference, tick,
  // gate and clear down, and count, match and pin level back
  // Per timer links to the counters
  gct_tmr_if tif [NTMR] ();

  // Glue between the register file, the edge detectors
  // and the counters; all of it combinational
  logic [NTMR-1:0]            pin_w;    // Input pins as a vector
  logic [NTMR-1:0]            pin_evt;  // Selected pin edges
  logic [NTMR-1:0]            gate_pin; // Gate pin of each timer
  logic [NTMR-1:0]            match_w;  // Match pulses
  logic [NTMR-1:0]            tick_w;   // Count enables
  logic [NTMR-1:0]            clr_w;    // Counter clear by write
  logic [NTMR-1:0]            out_w;    // Output pin levels
  logic [NTMR-1:0][CNT_W-1:0] cnt_w;    // Counts
  logic                       div_tick; // Clock divided by sixteen
  logic                       xfer;     // APB access completes
  logic [IDX_W-1:0]           tsel;     // Addressed timer
  logic [IDX_LSB-1:0]         roff;     // Offset inside a timer
  logic                       is_tmr;   // Address in timer space
  logic                       hit;      // Address is mapped
  logic [DATA_W-1:0]          rd;       // Read mux

  // Input pins are taken as synchronous to the clock;
  // an asynchronous source needs a synchroniser outside
  assign pin_w = {timer_in_pin_four, timer_in_pin_three,
                  timer_in_pin_two, timer_in_pin_one};

  // Gate pins are synchronous too; a gate only matters
  // for timers whose selection bit is set
  // Each gate pin reaches only its own pair of timers
  assign gate_pin = {{(NTMR/2){gate_in_high_pair}},
                     {(NTMR/2){gate_in_low_pair}}};

  // The prescaler runs from reset whatever the modes are,
  // so the first divided tick may come early after a mode
  // write; a limitation software must allow for
  // One tick every sixteen cycles from the shared prescaler
  assign div_tick = (st_r.div == DIV_LAST);

  // Source choice per timer:
  //   System clock ticks every cycle
  //   Divided clock ticks once per sixteen cycles, shared
  //   Input pin ticks on the chosen edges, in the same cycle
  //   Chain ticks on the previous timer's match pulse
  // Chaining for a thirty two bit count:
  //   Lower timer counts to reference 0xffff and returns
  //   Upper timer takes the lower one's match as its tick
  //   Upper match comes one cycle after the lower one
  // The chain is a ring, so timer 1 can follow timer 4;
  // a ring of all four on chain sources never starts
  // counting, which is left to software to avoid
  // Edge detectors ignore their first sample after reset,
  // so a pin that is already high gives no false edge
  // Per timer source choice and counter
  genvar i;
  generate
    for (i = 0; i < NTMR; i++)
    begin : g_tmr
      // Edge detect of this timer's input pin
      gct_in_edge u_edge (
        .clock    (clock),
        .rstn     (rstn),
        .ce       (ce),
        .pin      (pin_w[i]),
        .edge_sel (st_r.mode[i].edg),
        .evt      (pin_evt[i])
      );

      // Count source; chain takes the previous timer's match
      always_comb
      begin
        // Every code is legal, so no default branch
        unique case (st_r.mode[i].src)
          SRC_SYS:   tick_w[i] = 1'b1;
          SRC_DIV16: tick_w[i] = div_tick;
          SRC_PIN:   tick_w[i] = pin_evt[i];
          SRC_CHAIN: tick_w[i] = match_w[(i+NTMR-1)%NTMR];
        endcase
      end

      // Drive the counter link
      assign tif[i].mode    = st_r.mode[i];
      assign tif[i].ref_v   = st_r.refv[i];
      assign tif[i].tick    = tick_w[i];
      assign tif[i].gate_en = st_r.gsel[i];
      assign tif[i].gate    = gate_pin[i];
      assign tif[i].clr     = clr_w[i];
      assign cnt_w[i]       = tif[i].cnt;
      assign match_w[i]     = tif[i].match;
      assign out_w[i]       = tif[i].pin_out;

      // The sixteen bit counter itself
      gct_timer_core u_core (
        .clock (clock),
        .rstn  (rstn),
        .ce    (ce),
        .tif   (tif[i])
      );
    end
  endgenerate

  // Pins idle high; a pulse is one cycle low, a toggle
  // holds its level until the next match
  // Output pins come straight from counter flops
  assign timer_out_pins = out_w;

  // Bus timing:
  //   Setup cycle latches read data into a flop, so the
  //   access cycle answers with no wait state
  //   Each cycle of low clock enable adds a wait
  //   Writes land only at the edge where pready is high
  // Trade: one flop stage on read data instead of a long
  // combinational path from the counters to the bus pins
  // Zero wait once read data is latched; frozen bus waits too
  assign xfer    = psel & penable & st_r.rdy & ce;
  assign pready  = xfer;
  assign prdata  = st_r.prdata;
  assign pslverr = xfer & st_r.slverr;

  // Address split: bits above the timer field must be zero
  // for timer space; the global words sit just above it
  // Count reads give the live value seen in the setup
  // cycle, not a snapshot taken across all timers
  // Address decode and read mux
  always_comb
  begin
    tsel   = paddr[IDX_MSB:IDX_LSB];
    roff   = paddr[IDX_LSB-1:0];
    is_tmr = (paddr[ADDR_W-1:IDX_MSB+1] == '0);
    hit    = 1'b0;
    rd     = '0;
    if (is_tmr)
    begin
      case (roff)
        // Timer index picks the word; holes inside a block
        // answer with an error like any unmapped address
        OFF_MODE:
        begin
          hit              = 1'b1;
          rd[MODE_W-1:0]   = st_r.mode[tsel];
        end
        OFF_REF:
        begin
          hit              = 1'b1;
          rd[CNT_W-1:0]    = st_r.refv[tsel];
        end
        OFF_CNT:
        begin
          hit              = 1'b1;
          rd[CNT_W-1:0]    = cnt_w[tsel];
        end
        OFF_CAP:
        begin
          hit              = 1'b1;
          rd[CNT_W-1:0]    = st_r.cap[tsel];
        end
        OFF_EVT:
        begin
          hit              = 1'b1;
          rd[EVT_W-1:0]    = st_r.evt[tsel];
        end
        default:
          hit              = 1'b0; // Holes inside a timer block
      endcase
    end
    else if (paddr == GCFG_ADDR)
    begin
      hit                  = 1'b1;
      rd[NTMR-1:0]         = st_r.gsel;
    end
    else if (paddr == STAT_ADDR)
    begin
      // Live pin levels, gates above outputs
      hit                  = 1'b1;
      rd[2*NTMR-1:0]       = {gate_pin, out_w};
    end
  end

  // Flag handling:
  //   Software clear is applied first, hardware set after,
  //   so an event in the clearing cycle is never lost
  //   Capture takes the live count whatever the source,
  //   also while the timer is disabled
  // Counter clear goes to the core as a one cycle strobe
  // Register writes, read latch and event flags
  always_comb
  begin
    st_nxt     = st_r;
    clr_w      = '0;
    st_nxt.div = DIV_W'(st_r.div + 1'b1);
    // Latch read data before the access so prdata is a flop
    // Ready flag set in the setup cycle, dropped at the
    // completing edge so back to back transfers latch again
    st_nxt.rdy = psel & ~xfer;
    if (psel && !st_r.rdy)
    begin
      st_nxt.prdata = pwrite ? '0 : rd;
      st_nxt.slverr = ~hit;
    end
    // Writes take effect at the completing edge only
    if (xfer && pwrite && hit)
    begin
      if (is_tmr)
      begin
        case (roff)
          OFF_MODE: st_nxt.mode[tsel] =
                      gct_mode_s'(pwdata[MODE_W-1:0]);
          OFF_REF:  st_nxt.refv[tsel] = pwdata[CNT_W-1:0];
          OFF_CNT:  clr_w[tsel]       = 1'b1;
          OFF_EVT:  st_nxt.evt[tsel]  =
                      st_r.evt[tsel] & ~pwdata[EVT_W-1:0];
          // A capture write is ignored without an error
          default:  clr_w             = '0; // Capture is read only
        endcase
      end
      else if (paddr == GCFG_ADDR)
        st_nxt.gsel = pwdata[NTMR-1:0];
    end
    // Hardware sets after the clear, so a same cycle event stays
    for (int k = 0; k < NTMR; k++)
    begin
      if (pin_evt[k])
      begin
        st_nxt.cap[k]          = cnt_w[k];
        st_nxt.evt[k][EVT_CAP] = 1'b1;
      end
      if (match_w[k])
        st_nxt.evt[k][EVT_MATCH] = 1'b1;
    end
  end

  // Register file and bus state sit in one struct; a low clock enable holds
  // every field, the prescaler included, so a frozen block
  // resumes exactly where it stopped
  // State register, held while frozen
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

endmodule

//--- rtl/gct_pkg.sv
package gct_pkg;

  // Sizes of the timer set
  localparam int NTMR   = 4;  // Number of timers
  localparam int CNT_W  = 16; // Counter and reference width
  localparam int DATA_W = 32; // APB data width
  localparam int ADDR_W = 12; // APB address width
  localparam int MODE_W = 8;  // Mode register width
  localparam int EVT_W  = 2;  // Event flag width
  localparam int DIV_W  = 4;  // Prescaler width, divide by sixteen

  // Prescaler wraps here once every sixteen cycles
  localparam logic [DIV_W-1:0] DIV_LAST = 4'hf;

  // Address layout: timer index in bits 6:5, offset in 4:0
  localparam int IDX_LSB = 5;
  localparam int IDX_MSB = 6;
  localparam int IDX_W   = IDX_MSB - IDX_LSB + 1;

  // Per timer register offsets, timer base is index times 0x20
  localparam logic [IDX_LSB-1:0] OFF_MODE = 5'h00;
  localparam logic [IDX_LSB-1:0] OFF_REF  = 5'h04;
  localparam logic [IDX_LSB-1:0] OFF_CNT  = 5'h08;
  localparam logic [IDX_LSB-1:0] OFF_CAP  = 5'h0c;
  localparam logic [IDX_LSB-1:0] OFF_EVT  = 5'h10;

  // Global registers
  localparam logic [ADDR_W-1:0] GCFG_ADDR = 12'h080;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h084;

  // Event flag positions
  localparam int EVT_MATCH = 0;
  localparam int EVT_CAP   = 1;

  // Idle level of an output pin, pulses go low
  localparam logic OUT_IDLE = 1'b1;

  // Count source
  typedef enum logic [1:0] {
    SRC_SYS,
    SRC_DIV16,
    SRC_PIN,
    SRC_CHAIN
  } gct_src_e;

  // Input pin edge choice, last code unused
  typedef enum logic [1:0] {
    EDG_RISE,
    EDG_FALL,
    EDG_BOTH
  } gct_edge_e;

  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic      en;       // Timer runs
    logic      ref_rst;  // Counter returns to zero at match
    logic      gate_rst; // Gate rising edge restarts count
    logic      toggle;   // One: toggle, zero: low pulse
    gct_edge_e edg;      // Input pin edges used
    gct_src_e  src;      // Count source
  } gct_mode_s;

  localparam gct_mode_s MODE_RST = '0;

endpackage

//--- rtl/gct_tmr_if.sv
`timescale 1ns/10ps
interface gct_tmr_if;
  import gct_pkg::*;

  gct_mode_s         mode;    // Mode of this timer
  logic [CNT_W-1:0]  ref_v;   // Reference value
  logic              tick;    // Count enable for this cycle
  logic              gate_en; // Gate pin steers this timer
  logic              gate;    // Gate pin level, high lets it count
  logic              clr;     // Software clears the counter
  logic [CNT_W-1:0]  cnt;     // Present count
  logic              match;   // One cycle pulse after a match
  logic              pin_out; // Output pin level

  // Register side and counter side
  modport ctl  (output mode, ref_v, tick, gate_en, gate, clr,
                input  cnt, match, pin_out);
  modport core (input  mode, ref_v, tick, gate_en, gate, clr,
                output cnt, match, pin_out);

endinterface

//--- rtl/gct_in_edge.sv
`timescale 1ns/10ps
module gct_in_edge
  import gct_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic      clock,
  input  wire logic      rstn,
  input  wire logic      ce,
  // Pin and edge choice
  input  wire logic      pin,
  input  gct_edge_e      edge_sel,
  // One cycle event
  output logic           evt
);

  // Previous pin level and a flag that it is valid
  typedef struct packed {
    logic armed;
    logic pin_q;
  } gct_edge_s;

  gct_edge_s st_r;   // State
  gct_edge_s st_nxt; // Next state

  // Edge compare, suppressed until one sample is held
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.armed = 1'b1;
    st_nxt.pin_q = pin;
    evt          = 1'b0;
    unique case (edge_sel)
      EDG_RISE: evt = st_r.armed & pin & ~st_r.pin_q;
      EDG_FALL: evt = st_r.armed & ~pin & st_r.pin_q;
      EDG_BOTH: evt = st_r.armed & (pin ^ st_r.pin_q);
      default:  evt = 1'b0; // Unused code gives no edges
    endcase
  end

  // State register, held while frozen
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else if (ce)
      st_r <= st_nxt;
  end

endmodule

//--- rtl/gct_timer_core.sv
`timescale 1ns/10ps
module gct_timer_core
  import gct_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic  clock,
  input  wire logic  rstn,
  input  wire logic  ce,
  // Register side link
  gct_tmr_if.core    tif
);

  // Counter state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;    // Count
    logic             out;    // Pin level
    logic             match;  // Match pulse to chain and flags
    logic             gate_q; // Gate level one cycle back
  } gct_core_s;

  localparam gct_core_s CORE_RST = '{cnt: '0, out: OUT_IDLE,
                                     match: 1'b0, gate_q: 1'b0};

  gct_core_s st_r;    // State
  gct_core_s st_nxt;  // Next state
  logic      permit;  // Gate lets the timer count
  logic      restart; // Gate asked for a fresh count
  logic      step;    // Counter advances this cycle
  logic      hit;     // Count equals reference on a step

  // Count, compare and drive the pin
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.gate_q = tif.gate;
    permit  = ~tif.gate_en | tif.gate;
    restart = tif.gate_en & tif.mode.gate_rst
              & tif.gate & ~st_r.gate_q;
    step    = tif.mode.en & permit & tif.tick & ~restart & ~tif.clr;
    hit     = step & (st_r.cnt == tif.ref_v);
    // Clear and restart win over counting
    if (tif.clr || restart)
      st_nxt.cnt = '0;
    else if (step)
    begin
      // Free run wraps on its own after the last count
      if (hit && tif.mode.ref_rst)
        st_nxt.cnt = '0;
      else
        st_nxt.cnt = CNT_W'(st_r.cnt + 1'b1);
    end
    st_nxt.match = hit;
    // Toggle keeps its level, a pulse lasts one cycle low
    if (tif.mode.toggle)
      st_nxt.out = st_r.out ^ hit;
    else
      st_nxt.out = ~hit;
  end

  // State register, held while frozen
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= CORE_RST;
    else if (ce)
      st_r <= st_nxt;
  end

  // Results back to the register side
  assign tif.cnt     = st_r.cnt;
  assign tif.match   = st_r.match;
  assign tif.pin_out = st_r.out;

endmodule

//--- rtl/gct_pkg_unused_guard.sv
`timescale 1ns/10ps

//--- dv/gct_timer_set_asserts.sv
`timescale 1ns/10ps
module gct_asserts
  import gct_pkg::*;
(
  // Clock, reset, freeze
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic              ce,
  // APB slave side
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Pins
  input wire logic              gate_in_low_pair,
  input wire logic              gate_in_high_pair,
  input wire logic [NTMR-1:0]   timer_out_pins
);
  logic [MODE_W-1:0] mode0_r; // Copy of timer 1 mode
  logic [NTMR-1:0]   gcfg_r;  // Copy of gate selection
  logic              wr_ok;   // Accepted write this edge

  assign wr_ok = psel & penable & pready & pwrite & ~pslverr;

  // Shadow keeps only what the pin checks need, so it stays tiny
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      mode0_r <= '0;
      gcfg_r  <= '0;
    end
    else if (wr_ok && paddr == 12'h000)
      mode0_r <= pwdata[MODE_W-1:0];
    else if (wr_ok && paddr == GCFG_ADDR)
      gcfg_r <= pwdata[NTMR-1:0];

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Low pulse lasts exactly one cycle
  sequence low_pulse;
    !timer_out_pins[0] ##1 timer_out_pins[0];
  endsequence

  rdy_form_a: assert property (pready == (psel && penable && ce))
    else $error("pready outside access phase");
  rdy_once_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_data_a: assert property (pslverr |-> prdata == '0)
    else $error("refused access returned data");
  pulse_one_a: assert property (
    $fell(timer_out_pins[0]) && !mode0_r[4] && !$past(mode0_r[4])
    |-> low_pulse)
    else $error("pulse not one cycle");
  fall_en_a: assert property (
    $fell(timer_out_pins[0]) |-> $past(mode0_r[7]))
    else $error("output moved with timer off");
  gate_low_a: assert property (
    $fell(timer_out_pins[0]) && $past(gcfg_r[0]) |->
    $past(gate_in_low_pair))
    else $error("gated timer 1 counted");
  gate_high_a: assert property (
    $fell(timer_out_pins[2]) && $past(gcfg_r[2]) |->
    $past(gate_in_high_pair))
    else $error("gated timer 3 counted");
endmodule

bind gct_timer_set gct_asserts chk_u (.clock, .rstn, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .gate_in_low_pair, .gate_in_high_pair, .timer_out_pins);

//--- dv/gct_pins_model.sv
`timescale 1ns/10ps
module gct_pins_model
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Bench requests
  input  wire logic [1:0] gate_req,
  input  wire logic [3:0] in_run,
  // Pins toward the timers
  output logic            gate_in_low_pair,
  output logic            gate_in_high_pair,
  output logic      [3:0] in_pins
);
  logic [1:0] ph_r; // Square wave phase, restarts per burst

  // Gates follow a cycle late; inputs give whole periods of 4 cycles
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      gate_in_low_pair  <= 1'b0;
      gate_in_high_pair <= 1'b0;
      ph_r              <= 2'h0;
      in_pins           <= 4'h0;
    end
    else
    begin
      gate_in_low_pair  <= gate_req[0];
      gate_in_high_pair <= gate_req[1];
      ph_r              <= (|in_run) ? ph_r + 2'h1 : 2'h0;
      in_pins           <= in_run & {4{ph_r[1]}};
    end
endmodule

//--- dv/test_gct_timer_set.sv
`timescale 1ns/10ps
module test_gct_timer_set;
  import gct_pkg::*;

  logic              clock = 1'b0;             // System clock
  logic              rstn, ce, psel, penable;  // Control
  logic              pwrite, pready, pslverr;  // APB
  logic [ADDR_W-1:0] paddr;                    // APB address
  logic [DATA_W-1:0] pwdata, prdata, q, f1, f2; // Data, read copies
  logic              e, glo, ghi;              // Error copy, gates
  logic [NTMR-1:0]   pins, in_p, in_run;       // Pin groups
  logic [1:0]        gate_req;                 // Gate levels asked
  int                errors = 0;               // Mismatches
  int                check_count = 0;          // Comparisons
  int                n;                        // Measured count
  int                exp_n [3] = '{4, 4, 8};   // Matches per edge code

  always #2.5 clock = ~clock;

  gct_timer_set dut_u (.clock, .rstn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .gate_in_low_pair(glo),
    .gate_in_high_pair(ghi), .timer_in_pin_one(in_p[0]),
    .timer_in_pin_two(in_p[1]), .timer_in_pin_three(in_p[2]),
    .timer_in_pin_four(in_p[3]), .timer_out_pins(pins));
  gct_pins_model pm_u (.clock, .rstn, .gate_req, .in_run,
    .gate_in_low_pair(glo), .gate_in_high_pair(ghi), .in_pins(in_p));

  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // One APB transfer; answer and read data taken at the very edge
  // where pready is high, read before that edge's updates land
  task apb(input logic w, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    ck(k < 50, "no pready");
  endtask

  // Cycles between the second and third event on one pin, so a
  // level left over from a mode change is never measured
  task gap(input int i, input logic any);
    logic p;
    int   s, k;
    s = 0;
    k = 0;
    n = 0;
    @(negedge clock);
    p = pins[i];
    while (s < 3 && k < 400)
    begin
      @(negedge clock);
      k++;
      if (s == 2)
        n++;
      if (any ? pins[i] !== p : (p === 1'b1 && pins[i] === 1'b0))
        s++;
      p = pins[i];
    end
  endtask

  task falls(input int i, input int cyc);
    logic p;
    n = 0;
    p = pins[i];
    repeat (cyc)
    begin
      @(negedge clock);
      if (p === 1'b1 && pins[i] === 1'b0)
        n++;
      p = pins[i];
    end
  endtask

  task done(input string t);
    $display("test %s finished", t);
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    $display("unexpected at %0t: watchdog", $time);
    results;
  end

  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gate_req, in_run} = '0;
    ce = 1'b1;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    ck(pins === 4'hf, "pins not idle");
    apb(1'b0, 12'h000, '0);
    ck(q === 32'h0, "mode reset value");
    apb(1'b1, 12'h004, 32'hffffabcd);
    apb(1'b0, 12'h004, '0);
    ck(q === 32'h0000abcd, "reference width");
    apb(1'b0, 12'h088, '0);
    ck(e === 1'b1 && q === 32'h0, "unmapped read");
    done("registers");
    // Pulse every REF+1 clocks
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h000, 32'hc0);
    apb(1'b0, 12'h000, '0);
    ck(q === 32'hc0, "mode readback");
    gap(0, 1'b0);
    ck(n == 3, "pulse period");
    apb(1'b1, 12'h000, 32'hd0);
    gap(0, 1'b1);
    ck(n == 3, "toggle period");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'hc1);
    apb(1'b1, 12'h008, 32'h0);
    gap(0, 1'b0);
    ck(n == 16, "divided clock period");
    done("output modes");
    // Timer 2 counts timer 1 matches
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h024, 32'h2);
    apb(1'b1, 12'h020, 32'hc3);
    apb(1'b1, 12'h000, 32'hc0);
    gap(1, 1'b0);
    ck(n == 12, "chained period");
    apb(1'b1, 12'h000, 32'h0);
    done("chain");
    // Input pin source, each edge choice
    apb(1'b1, 12'h024, 32'h1);
    for (int j = 0; j < 3; j++)
    begin
      apb(1'b1, 12'h020, 32'hc2 | (j << 2));
      apb(1'b1, 12'h028, 32'h0);
      fork
        begin
          in_run <= 4'hf;
          repeat (32) @(posedge clock);
          in_run <= 4'h0;
        end
        falls(1, 40);
      join
      ck(n == exp_n[j], "pin edge count");
    end
    apb(1'b1, 12'h020, 32'h0);
    done("input pins");
    // Gating on the two pairs, restart on the low pair
    apb(1'b1, GCFG_ADDR, 32'h5);
    gate_req <= 2'b11;
    apb(1'b1, 12'h004, 32'h40);
    apb(1'b1, 12'h044, 32'h20);
    apb(1'b1, 12'h000, 32'he0);
    apb(1'b1, 12'h040, 32'hc0);
    repeat (30) @(posedge clock);
    gate_req <= 2'b10;
    repeat (4) @(posedge clock);
    apb(1'b0, 12'h008, '0);
    f1 = q;
    repeat (10) @(posedge clock);
    apb(1'b0, 12'h008, '0);
    ck(q === f1 && f1 !== 32'h0, "gate low held count");
    apb(1'b0, 12'h048, '0);
    f2 = q;
    apb(1'b0, 12'h048, '0);
    ck(q !== f2, "high pair timer stalled");
    f2 = q;
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    ce <= 1'b1;
    apb(1'b0, 12'h048, '0);
    ck((q + 32'd33 - f2) % 32'd33 == 32'd3, "count moved while frozen");
    gate_req <= 2'b11;
    repeat (3) @(posedge clock);
    apb(1'b0, 12'h008, '0);
    ck((q < f1) === 1'b1, "gate rise no restart");
    repeat (80) @(posedge clock);
    done("gates");
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    ck(pins === 4'hf, "pins after reset");
    done("reset");
    results;
  end
endmodule
